// ### hw/crmh_pkg.sv
// Shared constants and types of the CAN receive message handler
package crmh_pkg;
	// Object count default and frame field widths
	localparam int NUM_OBJ_DEF = 32;
	localparam int ID_W        = 29;
	localparam int STD_LOW_W   = 18;
	localparam int DLC_W       = 4;
	localparam int DATA_W      = 64;
	localparam int HALF_W      = 32;
	localparam int FRAME_W     = ID_W + 2 + DLC_W + DATA_W;
	localparam int BUF_DEPTH   = 2;
	// Frame vector layout: {id, xtd, rtr, dlc, data}
	localparam int FR_ID_HI    = FRAME_W - 1;
	localparam int FR_XTD      = DLC_W + DATA_W + 1;
	localparam int FR_RTR      = DLC_W + DATA_W;
	localparam int FR_DLC_HI   = DLC_W + DATA_W - 1;
	// Command mask bit positions
	localparam int CMD_W       = 8;
	localparam int CM_DATA_A   = 0;
	localparam int CM_DATA_B   = 1;
	localparam int CM_TXRQ_ND  = 2;
	localparam int CM_CLR_IRQ  = 3;
	localparam int CM_CTRL     = 4;
	localparam int CM_ARB      = 5;
	localparam int CM_MASK     = 6;
	localparam int CM_WR       = 7;
	localparam logic [CMD_W-1:0] CMD_READ_ALL = 8'h7F;
	// Control word bit positions
	localparam int CTRL_W      = 16;
	localparam int CT_ND       = 15;
	localparam int CT_LOST     = 14;
	localparam int CT_IRQP     = 13;
	localparam int CT_USE_MASK    = 12;
	localparam int CT_TRANSMIT_IRQ_ENABLE     = 11;
	localparam int CT_RECEIVE_IRQ_ENABLE     = 10;
	localparam int CT_RMT      = 9;
	localparam int CT_TXRQ     = 8;
	localparam int CT_EOB      = 7;
	localparam int CT_VALID    = 6;
	// Values after reset
	localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [1:0]        CNT_RESET  = 2'h0;
	typedef enum {RX_IGNORE, RX_DATA, RX_REMOTE_REPLY, RX_REMOTE_STORE} crmh_act_t;
endpackage

// ### hw/crmh_top.sv
// CAN receive message handler: frame buffer, acceptance match, object store
// Functional notes
// - Store matched frame's arbitration, length and data into the object
// - Storing new content sets the object's new-data flag
// - Storing over set new-data sets message-lost
// - Data frame store with receive interrupt enabled sets irq-pending
// - Data frame store clears transmit-request
// - Remote frame, send object, remote enabled: set only transmit-request
// - Remote frame, remote disabled, no mask: ignore, transmit-request unchanged
// - Remote frame, remote disabled, mask: clear request, store header, set new-data
// - Standard objects match upper 11 id bits; standard frames store zeros in lower 18
// - Data store writes length code and all eight data bytes
// - With use-mask, masked id, format and direction bits are not compared
// - Read command copies object out except the mask direction bit (reads 0), clears new-data and irq-pending per mask
// - Message-lost clears only by a software write
// - FIFO frame goes to lowest available member, setting new-data
// - Members with new-data and no end-of-block are skipped
// - Full FIFO overwrites the last member
// - FIFO read with new-data and irq mask bits clears both flags
// - Lowest-numbered matching object receives the frame
`timescale 1ns/10ps
`default_nettype none
module crmh_top #(
	parameter int NUM_OBJ = crmh_pkg::NUM_OBJ_DEF,
	localparam int OBJ_W = $clog2(NUM_OBJ)
) (
	input  wire logic                          mclk,
	input  wire logic                          srst,
	input  wire logic                          rx_valid,
	output logic                               rx_ready,
	input  wire logic [crmh_pkg::ID_W-1:0]     rx_id,
	input  wire logic                          rx_xtd,
	input  wire logic                          rx_rtr,
	input  wire logic [crmh_pkg::DLC_W-1:0]    rx_dlc,
	input  wire logic [crmh_pkg::DATA_W-1:0]   rx_data,
	input  wire logic                          cmd_valid,
	input  wire logic [crmh_pkg::CMD_W-1:0]    cmd_mask,
	input  wire logic [OBJ_W-1:0]              cmd_obj,
	input  wire logic [crmh_pkg::ID_W-1:0]     wr_id,
	input  wire logic                          wr_xtd,
	input  wire logic                          wr_dir,
	input  wire logic [crmh_pkg::ID_W-1:0]     wr_mask_id,
	input  wire logic                          wr_mask_xtd,
	input  wire logic                          wr_mask_dir,
	input  wire logic [crmh_pkg::CTRL_W-1:0]   wr_ctrl,
	input  wire logic [crmh_pkg::DATA_W-1:0]   wr_data,
	output logic                               cmd_done,
	output logic [crmh_pkg::ID_W-1:0]          rd_id,
	output logic                               rd_xtd,
	output logic                               rd_dir,
	output logic [crmh_pkg::ID_W-1:0]          rd_mask_id,
	output logic                               rd_mask_xtd,
	output logic                               rd_mask_dir,
	output logic [crmh_pkg::CTRL_W-1:0]        rd_ctrl,
	output logic [crmh_pkg::DATA_W-1:0]        rd_data,
	output logic                               store_pulse,
	output logic [OBJ_W-1:0]                   store_obj,
	output logic [NUM_OBJ-1:0]                 transmit_request_flag,
	output logic [NUM_OBJ-1:0]                 new_data_flag,
	output logic [NUM_OBJ-1:0]                 irq_pending_flag
);
	// Two-entry frame buffer
	logic [crmh_pkg::FRAME_W-1:0] buf_reg  [crmh_pkg::BUF_DEPTH];
	logic [crmh_pkg::FRAME_W-1:0] buf_next [crmh_pkg::BUF_DEPTH];
	logic [1:0]                   cnt_reg, cnt_next, cnt_pop;
	logic                         in_ready_reg, in_ready_next;
	logic                         pop, push;

	// Frames wait while a command runs, which stalls the buffer and its source
	always_comb begin
		pop = (cnt_reg != 2'h0) && !cmd_valid;
		push = rx_valid && in_ready_reg;
		buf_next = buf_reg;
		cnt_pop = cnt_reg - {1'b0, pop};
		if (pop) begin
			buf_next[0] = buf_reg[1];
		end
		if (push) begin
			buf_next[cnt_pop[0]] = {rx_id, rx_xtd, rx_rtr, rx_dlc, rx_data};
		end
		cnt_next = cnt_pop + {1'b0, push};
		in_ready_next = cnt_next < 2'(crmh_pkg::BUF_DEPTH);
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cnt_reg <= crmh_pkg::CNT_RESET;
			in_ready_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			in_ready_reg <= in_ready_next;
		end
		buf_reg <= buf_next;
	end

	assign rx_ready = in_ready_reg;

	// Head frame fields
	logic [crmh_pkg::ID_W-1:0]   h_id, st_id;
	logic                        h_xtd, h_rtr;
	logic [crmh_pkg::DLC_W-1:0]  h_dlc;
	logic [crmh_pkg::DATA_W-1:0] h_data;
	assign h_id   = buf_reg[0][crmh_pkg::FR_ID_HI -: crmh_pkg::ID_W];
	assign h_xtd  = buf_reg[0][crmh_pkg::FR_XTD];
	assign h_rtr  = buf_reg[0][crmh_pkg::FR_RTR];
	assign h_dlc  = buf_reg[0][crmh_pkg::FR_DLC_HI -: crmh_pkg::DLC_W];
	assign h_data = buf_reg[0][crmh_pkg::DATA_W-1:0];
	assign st_id = h_xtd ? h_id
		: {h_id[crmh_pkg::ID_W-1:crmh_pkg::STD_LOW_W], {crmh_pkg::STD_LOW_W{1'b0}}};

	// Message objects
	logic [crmh_pkg::ID_W-1:0]   id_reg  [NUM_OBJ], id_next  [NUM_OBJ];
	logic [crmh_pkg::ID_W-1:0]   mid_reg [NUM_OBJ], mid_next [NUM_OBJ];
	logic [crmh_pkg::DLC_W-1:0]  dlc_reg [NUM_OBJ], dlc_next [NUM_OBJ];
	logic [crmh_pkg::DATA_W-1:0] data_reg[NUM_OBJ], data_next[NUM_OBJ];
	logic [NUM_OBJ-1:0] xtd_reg, xtd_next, dir_reg, dir_next, mask_format_bit_reg, mask_format_bit_next;
	logic [NUM_OBJ-1:0] mask_direction_bit_reg, mask_direction_bit_next, use_mask_reg, use_mask_next, eob_reg, eob_next;
	logic [NUM_OBJ-1:0] valid_reg, valid_next, nd_reg, nd_next, lost_reg, lost_next;
	logic [NUM_OBJ-1:0] receive_irq_enable_reg, receive_irq_enable_next, transmit_irq_enable_reg, transmit_irq_enable_next, irqp_reg, irqp_next;
	logic [NUM_OBJ-1:0] rmt_reg, rmt_next, txrq_reg, txrq_next, hit;
	logic [OBJ_W-1:0]   hit_idx, store_obj_reg, store_obj_next;
	logic               hit_any, fire, done_reg, done_next, store_reg, store_next;
	crmh_pkg::crmh_act_t act;
	logic [crmh_pkg::ID_W-1:0]   rd_id_reg, rd_id_next, rd_mid_reg, rd_mid_next;
	logic [crmh_pkg::CTRL_W-1:0] rd_ctrl_reg, rd_ctrl_next;
	logic [crmh_pkg::DATA_W-1:0] rd_data_reg, rd_data_next;
	logic [2:0]                  rd_bits_reg, rd_bits_next;

	// Acceptance match over all objects
	always_comb begin
		logic [crmh_pkg::ID_W-1:0] idm;
		logic xtd_ok;
		logic dir_ok;
		idm = '0;
		xtd_ok = 1'b0;
		dir_ok = 1'b0;
		hit = '0;
		for (int i = 0; i < NUM_OBJ; i++) begin
			// masked bits left out of comparison
			idm = use_mask_reg[i] ? mid_reg[i] : {crmh_pkg::ID_W{1'b1}};
			if (!xtd_reg[i]) begin
				idm[crmh_pkg::STD_LOW_W-1:0] = '0;
			end
			xtd_ok = (h_xtd == xtd_reg[i]) || (use_mask_reg[i] && !mask_format_bit_reg[i]);
			dir_ok = (h_rtr == dir_reg[i]) || (use_mask_reg[i] && !mask_direction_bit_reg[i]);
			// protected members skipped; last member never protected
			hit[i] = valid_reg[i] && (((h_id ^ id_reg[i]) & idm) == '0) && xtd_ok && dir_ok
				&& !(nd_reg[i] && !eob_reg[i]);
		end
		hit_idx = '0;
		// lowest number wins; lowest free FIFO member
		for (int i = NUM_OBJ - 1; i >= 0; i--) begin
			if (hit[i]) begin
				hit_idx = OBJ_W'(i);
			end
		end
		hit_any = |hit;
		if (!h_rtr) begin
			act = crmh_pkg::RX_DATA;
		end else if (rmt_reg[hit_idx]) begin
			act = crmh_pkg::RX_REMOTE_REPLY;
		end else if (use_mask_reg[hit_idx]) begin
			act = crmh_pkg::RX_REMOTE_STORE;
		end else begin
			act = crmh_pkg::RX_IGNORE;
		end
	end

	assign fire = pop && hit_any;

	// Object update: commands and frame stores never share a cycle
	always_comb begin
		id_next = id_reg;
		mid_next = mid_reg;
		dlc_next = dlc_reg;
		data_next = data_reg;
		xtd_next = xtd_reg;
		dir_next = dir_reg;
		mask_format_bit_next = mask_format_bit_reg;
		mask_direction_bit_next = mask_direction_bit_reg;
		use_mask_next = use_mask_reg;
		eob_next = eob_reg;
		valid_next = valid_reg;
		nd_next = nd_reg;
		lost_next = lost_reg;
		receive_irq_enable_next = receive_irq_enable_reg;
		transmit_irq_enable_next = transmit_irq_enable_reg;
		irqp_next = irqp_reg;
		rmt_next = rmt_reg;
		txrq_next = txrq_reg;
		rd_id_next = rd_id_reg;
		rd_mid_next = rd_mid_reg;
		rd_ctrl_next = rd_ctrl_reg;
		rd_data_next = rd_data_reg;
		rd_bits_next = rd_bits_reg;
		done_next = cmd_valid;
		store_next = 1'b0;
		store_obj_next = store_obj_reg;
		if (cmd_valid && cmd_mask[crmh_pkg::CM_WR]) begin
			if (cmd_mask[crmh_pkg::CM_MASK]) begin
				mid_next[cmd_obj] = wr_mask_id;
				mask_format_bit_next[cmd_obj] = wr_mask_xtd;
				mask_direction_bit_next[cmd_obj] = wr_mask_dir;
			end
			if (cmd_mask[crmh_pkg::CM_ARB]) begin
				id_next[cmd_obj] = wr_id;
				xtd_next[cmd_obj] = wr_xtd;
				dir_next[cmd_obj] = wr_dir;
			end
			// the only path that clears message-lost
			if (cmd_mask[crmh_pkg::CM_CTRL]) begin
				nd_next[cmd_obj] = wr_ctrl[crmh_pkg::CT_ND];
				lost_next[cmd_obj] = wr_ctrl[crmh_pkg::CT_LOST];
				irqp_next[cmd_obj] = wr_ctrl[crmh_pkg::CT_IRQP];
				use_mask_next[cmd_obj] = wr_ctrl[crmh_pkg::CT_USE_MASK];
				transmit_irq_enable_next[cmd_obj] = wr_ctrl[crmh_pkg::CT_TRANSMIT_IRQ_ENABLE];
				receive_irq_enable_next[cmd_obj] = wr_ctrl[crmh_pkg::CT_RECEIVE_IRQ_ENABLE];
				rmt_next[cmd_obj] = wr_ctrl[crmh_pkg::CT_RMT];
				txrq_next[cmd_obj] = wr_ctrl[crmh_pkg::CT_TXRQ];
				eob_next[cmd_obj] = wr_ctrl[crmh_pkg::CT_EOB];
				valid_next[cmd_obj] = wr_ctrl[crmh_pkg::CT_VALID];
				dlc_next[cmd_obj] = wr_ctrl[crmh_pkg::DLC_W-1:0];
			end
			if (cmd_mask[crmh_pkg::CM_TXRQ_ND]) begin
				txrq_next[cmd_obj] = 1'b1;
			end
			if (cmd_mask[crmh_pkg::CM_DATA_A]) begin
				data_next[cmd_obj][crmh_pkg::HALF_W-1:0] = wr_data[crmh_pkg::HALF_W-1:0];
			end
			if (cmd_mask[crmh_pkg::CM_DATA_B]) begin
				data_next[cmd_obj][crmh_pkg::DATA_W-1:crmh_pkg::HALF_W] =
					wr_data[crmh_pkg::DATA_W-1:crmh_pkg::HALF_W];
			end
		end else if (cmd_valid) begin
			// copy object out except mask direction bit, then clear flags per mask
			rd_id_next = id_reg[cmd_obj];
			rd_mid_next = mid_reg[cmd_obj];
			rd_data_next = data_reg[cmd_obj];
			rd_bits_next = {xtd_reg[cmd_obj], dir_reg[cmd_obj], 1'b0};
			rd_bits_next[0] = mask_format_bit_reg[cmd_obj];
			rd_ctrl_next = crmh_pkg::CTRL_RESET;
			rd_ctrl_next[crmh_pkg::CT_ND] = nd_reg[cmd_obj];
			rd_ctrl_next[crmh_pkg::CT_LOST] = lost_reg[cmd_obj];
			rd_ctrl_next[crmh_pkg::CT_IRQP] = irqp_reg[cmd_obj];
			rd_ctrl_next[crmh_pkg::CT_USE_MASK] = use_mask_reg[cmd_obj];
			rd_ctrl_next[crmh_pkg::CT_TRANSMIT_IRQ_ENABLE] = transmit_irq_enable_reg[cmd_obj];
			rd_ctrl_next[crmh_pkg::CT_RECEIVE_IRQ_ENABLE] = receive_irq_enable_reg[cmd_obj];
			rd_ctrl_next[crmh_pkg::CT_RMT] = rmt_reg[cmd_obj];
			rd_ctrl_next[crmh_pkg::CT_TXRQ] = txrq_reg[cmd_obj];
			rd_ctrl_next[crmh_pkg::CT_EOB] = eob_reg[cmd_obj];
			rd_ctrl_next[crmh_pkg::CT_VALID] = valid_reg[cmd_obj];
			rd_ctrl_next[crmh_pkg::DLC_W-1:0] = dlc_reg[cmd_obj];
			// read clears new-data and irq-pending, releasing FIFO members
			if (cmd_mask[crmh_pkg::CM_CLR_IRQ]) begin
				irqp_next[cmd_obj] = 1'b0;
			end
			if (cmd_mask[crmh_pkg::CM_TXRQ_ND]) begin
				nd_next[cmd_obj] = 1'b0;
			end
		end
		// frames are only taken when no command is presented
		if (fire) begin
			unique case (act)
				crmh_pkg::RX_DATA: begin
					// full header and all eight bytes stored
					id_next[hit_idx] = st_id;
					xtd_next[hit_idx] = h_xtd;
					dlc_next[hit_idx] = h_dlc;
					data_next[hit_idx] = h_data;
					nd_next[hit_idx] = 1'b1;
					lost_next[hit_idx] = lost_reg[hit_idx] | nd_reg[hit_idx];
					irqp_next[hit_idx] = irqp_reg[hit_idx] | receive_irq_enable_reg[hit_idx];
					txrq_next[hit_idx] = 1'b0;
					store_next = 1'b1;
				end
				crmh_pkg::RX_REMOTE_REPLY: begin
					txrq_next[hit_idx] = 1'b1;
				end
				crmh_pkg::RX_REMOTE_STORE: begin
					id_next[hit_idx] = st_id;
					xtd_next[hit_idx] = h_xtd;
					dlc_next[hit_idx] = h_dlc;
					nd_next[hit_idx] = 1'b1;
					lost_next[hit_idx] = lost_reg[hit_idx] | nd_reg[hit_idx];
					txrq_next[hit_idx] = 1'b0;
					store_next = 1'b1;
				end
				crmh_pkg::RX_IGNORE: begin
					store_next = 1'b0;
				end
			endcase
			store_obj_next = hit_idx;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			valid_reg <= '0;
			nd_reg <= '0;
			lost_reg <= '0;
			irqp_reg <= '0;
			txrq_reg <= '0;
			rmt_reg <= '0;
			use_mask_reg <= '0;
			receive_irq_enable_reg <= '0;
			transmit_irq_enable_reg <= '0;
			eob_reg <= '0;
			done_reg <= 1'b0;
			store_reg <= 1'b0;
			store_obj_reg <= '0;
			rd_ctrl_reg <= crmh_pkg::CTRL_RESET;
			rd_bits_reg <= '0;
			rd_id_reg <= '0;
			rd_mid_reg <= '0;
			rd_data_reg <= '0;
		end else begin
			valid_reg <= valid_next;
			nd_reg <= nd_next;
			lost_reg <= lost_next;
			irqp_reg <= irqp_next;
			txrq_reg <= txrq_next;
			rmt_reg <= rmt_next;
			use_mask_reg <= use_mask_next;
			receive_irq_enable_reg <= receive_irq_enable_next;
			transmit_irq_enable_reg <= transmit_irq_enable_next;
			eob_reg <= eob_next;
			done_reg <= done_next;
			store_reg <= store_next;
			store_obj_reg <= store_obj_next;
			rd_ctrl_reg <= rd_ctrl_next;
			rd_bits_reg <= rd_bits_next;
			rd_id_reg <= rd_id_next;
			rd_mid_reg <= rd_mid_next;
			rd_data_reg <= rd_data_next;
		end
		id_reg <= id_next;
		mid_reg <= mid_next;
		dlc_reg <= dlc_next;
		data_reg <= data_next;
		xtd_reg <= xtd_next;
		dir_reg <= dir_next;
		mask_format_bit_reg <= mask_format_bit_next;
		mask_direction_bit_reg <= mask_direction_bit_next;
	end

	assign cmd_done = done_reg;
	assign rd_id = rd_id_reg;
	assign rd_xtd = rd_bits_reg[2];
	assign rd_dir = rd_bits_reg[1];
	assign rd_mask_id = rd_mid_reg;
	assign rd_mask_xtd = rd_bits_reg[0];
	assign rd_mask_dir = 1'b0 | rd_ctrl_reg[5];
	assign rd_ctrl = rd_ctrl_reg;
	assign rd_data = rd_data_reg;
	assign store_pulse = store_reg;
	assign store_obj = store_obj_reg;
	assign transmit_request_flag = txrq_reg;
	assign new_data_flag = nd_reg;
	assign irq_pending_flag = irqp_reg;

	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	logic data_fire;
	assign data_fire = fire && (act == crmh_pkg::RX_DATA);
	AST_ND_SET: assert property (data_fire |=> nd_reg[$past(hit_idx)])
		else $error("new-data not set after store");
	AST_LOST_SET: assert property (data_fire && nd_reg[hit_idx] |=> lost_reg[$past(hit_idx)])
		else $error("message-lost not set on overrun");
	AST_IRQ_SET: assert property (data_fire && receive_irq_enable_reg[hit_idx] |=> irqp_reg[$past(hit_idx)])
		else $error("irq-pending not set");
	AST_TXRQ_CLR: assert property (data_fire |=> !txrq_reg[$past(hit_idx)] && store_reg)
		else $error("transmit-request not cleared");
	AST_REPLY: assert property (fire && act == crmh_pkg::RX_REMOTE_REPLY |=> txrq_reg[$past(hit_idx)] && !store_reg)
		else $error("remote reply not requested");
	AST_IGNORE: assert property (fire && act == crmh_pkg::RX_IGNORE |=> txrq_reg == $past(txrq_reg))
		else $error("ignored remote frame changed request");
	AST_LOST_SW: assert property (((~lost_reg & $past(lost_reg)) != '0) |-> $past(cmd_valid && cmd_mask[crmh_pkg::CM_WR]))
		else $error("message-lost cleared by hardware");
	AST_STD_LOW: assert property (store_next && !h_xtd |=> id_reg[store_obj][crmh_pkg::STD_LOW_W-1:0] == '0)
		else $error("standard id low bits not zero");
	AST_NO_PROT: assert property (fire |-> !(nd_reg[hit_idx] && !eob_reg[hit_idx]))
		else $error("protected member overwritten");
	AST_READ_CLR: assert property (cmd_valid && cmd_mask == crmh_pkg::CMD_READ_ALL |=> !nd_reg[$past(cmd_obj)] && !irqp_reg[$past(cmd_obj)] && cmd_done)
		else $error("read did not clear flags");
	COV_DATA: cover property (data_fire);
	COV_OVERRUN: cover property (data_fire && nd_reg[hit_idx] && eob_reg[hit_idx]);
	COV_STALL: cover property (rx_valid && !rx_ready);
	COV_REMOTE_STORE: cover property (fire && act == crmh_pkg::RX_REMOTE_STORE);
endmodule
`default_nettype wire

// ### testbench/crmh_frame_src.sv
// Receive shift register model: offers queued frames with chosen gaps
`timescale 1ns/10ps
`default_nettype none
module crmh_frame_src (
	input  wire logic                           mclk,
	input  wire logic                           srst,
	output logic                                rx_valid,
	input  wire logic                           rx_ready,
	output logic [crmh_pkg::ID_W-1:0]           rx_id,
	output logic                                rx_xtd,
	output logic                                rx_rtr,
	output logic [crmh_pkg::DLC_W-1:0]          rx_dlc,
	output logic [crmh_pkg::DATA_W-1:0]         rx_data
);
	logic [crmh_pkg::FRAME_W-1:0] fq[$];
	int                           gq[$];
	logic [crmh_pkg::FRAME_W-1:0] cur;
	int                           wait_cnt;
	assign {rx_id, rx_xtd, rx_rtr, rx_dlc, rx_data} = cur;
	initial begin
		rx_valid = 1'b0;
		cur = '0;
		wait_cnt = 0;
	end
	// Released lines show the inverse of the last frame
	always @(posedge mclk) begin
		if (srst)
			rx_valid <= 1'b0;
		else if (rx_valid && rx_ready) begin
			rx_valid <= 1'b0;
			cur <= ~cur;
		end else if (!rx_valid && wait_cnt > 0)
			wait_cnt <= wait_cnt - 1;
		else if (!rx_valid && fq.size() > 0) begin
			rx_valid <= 1'b1;
			cur <= fq.pop_front();
			wait_cnt <= gq.pop_front();
		end
	end
endmodule
`default_nettype wire

// ### testbench/crmh_bench.sv
// Self-checking bench of the CAN receive message handler
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module crmh_bench;
	localparam int          NOBJ = 8;
	localparam logic [28:0] ID_A = {11'h123, 18'h00000};
	typedef struct {logic chk; logic [28:0] id; logic [15:0] cm, ct; logic [63:0] dm, dt;} crmh_exp_t;
	logic        mclk, srst, cmd_valid, wr_xtd, wr_dir, wr_mask_xtd, wr_mask_dir, cmd_done;
	logic        rx_valid, rx_ready, rx_xtd, rx_rtr, rd_xtd, rd_dir, rd_mask_xtd, rd_mask_dir;
	logic [28:0] rx_id, wr_id, wr_mask_id, rd_id, rd_mask_id;
	logic [63:0] rx_data, wr_data, rd_data, d1, d3, d4, dx, o5_data;
	logic [15:0] wr_ctrl, rd_ctrl;
	logic [7:0]  cmd_mask;
	logic [3:0]  rx_dlc;
	logic [2:0]  cmd_obj, store_obj;
	logic [NOBJ-1:0] transmit_request_flag, new_data_flag, irq_pending_flag;
	logic        store_pulse;
	logic [31:0] es;
	crmh_exp_t   e;
	crmh_exp_t   cq[$];
	logic [31:0] sq[$];
	int          seed, mismatches, comparisons;
	crmh_top #(.NUM_OBJ(NOBJ)) i_crmh_top (.mclk(mclk), .srst(srst), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_id(rx_id), .rx_xtd(rx_xtd), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc),
		.rx_data(rx_data), .cmd_valid(cmd_valid), .cmd_mask(cmd_mask), .cmd_obj(cmd_obj),
		.wr_id(wr_id), .wr_xtd(wr_xtd), .wr_dir(wr_dir), .wr_mask_id(wr_mask_id),
		.wr_mask_xtd(wr_mask_xtd), .wr_mask_dir(wr_mask_dir), .wr_ctrl(wr_ctrl),
		.wr_data(wr_data), .cmd_done(cmd_done), .rd_id(rd_id), .rd_xtd(rd_xtd), .rd_dir(rd_dir),
		.rd_mask_id(rd_mask_id), .rd_mask_xtd(rd_mask_xtd), .rd_mask_dir(rd_mask_dir),
		.rd_ctrl(rd_ctrl), .rd_data(rd_data), .store_pulse(store_pulse), .store_obj(store_obj),
		.transmit_request_flag(transmit_request_flag), .new_data_flag(new_data_flag),
		.irq_pending_flag(irq_pending_flag));
	crmh_frame_src i_crmh_frame_src (.mclk(mclk), .srst(srst), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_id(rx_id), .rx_xtd(rx_xtd), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc),
		.rx_data(rx_data));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic tally_and_finish();
		if (sq.size() > 0 || cq.size() > 0)
			mismatches++;
		$display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] m, input logic [2:0] o, input crmh_exp_t x);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_mask <= m;
		cmd_obj <= o;
		cq.push_back(x);
		@(posedge mclk);
		cmd_valid <= 1'b0;
	endtask
	task automatic wobj(input logic [2:0] o, input logic [28:0] id, input logic x, input logic d,
			input logic [15:0] ct, input logic [7:0] m);
		wr_id <= id;
		wr_xtd <= x;
		wr_dir <= d;
		wr_mask_id <= 29'h1FFFFF00;
		wr_mask_xtd <= 1'b1;
		wr_ctrl <= ct;
		wr_data <= {$random(seed), $random(seed)};
		cmd(m, o, '{default: '0});
	endtask
	task automatic rd(input logic [2:0] o, input logic [28:0] id, input logic [15:0] ct,
			input logic [63:0] dm, input logic [63:0] dt);
		cmd(8'h7F, o, '{1'b1, id, 16'hE10F, ct, dm, dt & dm});
	endtask
	task automatic frm(input logic [28:0] id, input logic x, input logic r, input logic [3:0] l,
			output logic [63:0] d);
		d = {$random(seed), $random(seed)};
		i_crmh_frame_src.fq.push_back({id, x, r, l, d});
		i_crmh_frame_src.gq.push_back($random(seed) & 3);
	endtask
	task automatic drain();
		int n;
		n = 0;
		while ((i_crmh_frame_src.fq.size() > 0 || rx_valid || sq.size() > 0) && n < 400) begin
			@(posedge mclk);
			n++;
		end
		repeat (6) @(posedge mclk);
	endtask
	always @(posedge mclk) begin
		if (!srst && store_pulse) begin
			es = (sq.size() > 0) ? sq.pop_front() : 32'hFFFFFFFF;
			`CHK({29'h00000000, store_obj}, es)
		end
		if (!srst && cmd_done && cq.size() > 0) begin
			e = cq.pop_front();
			if (e.chk) begin
				`CHK(rd_id, e.id)
				`CHK(rd_ctrl & e.cm, e.ct)
				`CHK(rd_data & e.dm, e.dt)
			end
		end
	end
	initial begin
		repeat (4000) @(posedge mclk);
		mismatches++;
		tally_and_finish();
	end
	initial begin
		seed = 49;
		mismatches = 0;
		comparisons = 0;
		srst = 1'b1;
		cmd_valid = 1'b0;
		cmd_mask = 8'h00;
		cmd_obj = 3'h0;
		{wr_id, wr_xtd, wr_dir, wr_mask_id, wr_mask_xtd, wr_ctrl, wr_data} = '0;
		wr_mask_dir = 1'b0;
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		wobj(3'h0, ID_A, 1'b0, 1'b0, 16'h0440, 8'hF3);
		wobj(3'h1, ID_A, 1'b0, 1'b0, 16'h04C0, 8'hF3);
		wobj(3'h2, 29'h1ABCDE00, 1'b1, 1'b0, 16'h10C0, 8'hF7);
		wobj(3'h3, {11'h2A5, 18'h00000}, 1'b0, 1'b1, 16'h02C0, 8'hF3);
		wobj(3'h4, {11'h3C1, 18'h00000}, 1'b0, 1'b1, 16'h00C0, 8'hF7);
		wobj(3'h5, {11'h0F0, 18'h00000}, 1'b0, 1'b1, 16'h10C0, 8'hF7);
		o5_data = wr_data;
		frm({11'h123, 18'($random(seed))}, 1'b0, 1'b0, 4'h8, d1);
		frm(ID_A, 1'b0, 1'b0, 4'h8, dx);
		frm(ID_A, 1'b0, 1'b0, 4'h8, d3);
		sq = '{0, 1, 1, 2, 5};
		frm(29'h1ABCDE5A, 1'b1, 1'b0, 4'h3, d4);
		frm({11'h2A5, 18'h00000}, 1'b0, 1'b1, 4'h0, dx);
		frm({11'h3C1, 18'h00000}, 1'b0, 1'b1, 4'h0, dx);
		frm({11'h0F0, 18'h00000}, 1'b0, 1'b1, 4'h5, dx);
		frm({11'h555, 18'h00000}, 1'b0, 1'b0, 4'h8, dx);
		drain();
		`CHK(new_data_flag, 8'h27)
		`CHK(irq_pending_flag, 8'h03)
		`CHK(transmit_request_flag, 8'h18)
		rd(3'h0, ID_A, 16'hA008, 64'hFFFFFFFFFFFFFFFF, d1);
		rd(3'h1, ID_A, 16'hE008, 64'hFFFFFFFFFFFFFFFF, d3);
		rd(3'h2, 29'h1ABCDE5A, 16'h8003, 64'h0000000000FFFFFF, d4);
		rd(3'h5, {11'h0F0, 18'h00000}, 16'h8005, 64'hFFFFFFFFFFFFFFFF, o5_data);
		rd(3'h1, ID_A, 16'h4008, 64'hFFFFFFFFFFFFFFFF, d3);
		repeat (2) @(posedge mclk);
		`CHK(new_data_flag | irq_pending_flag, 8'h00)
		// frames wait behind a command burst; buffer refuses
		frm(ID_A, 1'b0, 1'b0, 4'h8, dx);
		frm(ID_A, 1'b0, 1'b0, 4'h8, dx);
		frm(ID_A, 1'b0, 1'b0, 4'h8, dx);
		sq = '{0, 1, 1};
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_mask <= 8'h7F;
		cmd_obj <= 3'h7;
		repeat (8) begin
			@(posedge mclk);
			cq.push_back('{default: '0});
		end
		`CHK(rx_ready, 1'b0)
		cmd_valid <= 1'b0;
		drain();
		`CHK(new_data_flag, 8'h03)
		tally_and_finish();
	end
endmodule
`default_nettype wire
